// ### clock_source_ctrl.sv
// system clock source selection, enables, status and divider
`timescale 1ns/1ps
module clock_source_ctrl
  import clock_source_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  // protection and programming state from the core
  input wire logic accessUnlocked,
  input wire logic inAppProgramming,
  // oscillators and external clock pin
  input wire logic fastOscClk,
  input wire logic fastOscReady,
  input wire logic slowOscClk,
  input wire logic slowOscReady,
  input wire logic externalClockPin,
  input wire logic externalClockReady,
  // controls and clock out
  output logic fastOscEnable,
  output logic externalInputEnable,
  output logic [1:0] activeSource,
  output logic sysClk,
  output logic irq
);
  logic [LANES-1:0] syncA_reg, syncB_reg;
  logic [7:0] divider_reg, divider_next;
  logic [1:0] extEnable_reg, extEnable_next;
  logic fastEnable_reg, fastEnable_next;
  logic fault_reg, fault_next;
  source_t active_reg, active_next;
  source_t target_reg, target_next;
  switch_state_t state_reg, state_next;
  logic [IRQ_WIDTH-1:0] irqStatus_reg, irqStatus_next;
  logic [IRQ_WIDTH-1:0] irqEnable_reg, irqEnable_next;
  logic [7:0] rdData_reg, rdData_next;
  logic fastOn, extOn, fastStable, extStable, slowStable;
  logic wrSwitch, wrEnable, wrLocked, swapNow, faultEvent;
  logic [IRQ_WIDTH-1:0] irqEvents;
  logic selLevel;

  function automatic logic source_ready(input source_t src, input logic fs,
                                        input logic es, input logic ss);
    unique case (src)
      SRC_FAST: source_ready = fs;
      SRC_EXT: source_ready = es;
      SRC_SLOW: source_ready = ss;
      default: source_ready = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for oscillator levels and ready flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {slowOscReady, externalClockReady, fastOscReady,
                    slowOscClk, externalClockPin, fastOscClk};
      syncB_reg <= syncA_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables and stability
  always_comb begin
    fastOn = fastEnable_reg | inAppProgramming;
    extOn = (extEnable_reg == EXT_ENABLE_ON);
    fastStable = inAppProgramming | (fastOn & syncB_reg[LANE_FAST_RDY]);
    extStable = extOn & syncB_reg[LANE_EXT_RDY];
    slowStable = syncB_reg[LANE_SLOW_RDY];
    wrSwitch = wrStrobe & accessUnlocked & (addr == SWITCH_OFFSET);
    wrEnable = wrStrobe & accessUnlocked & (addr == ENABLE_OFFSET);
    wrLocked = wrStrobe & ~accessUnlocked &
               ((addr == SWITCH_OFFSET) | (addr == ENABLE_OFFSET));
  end

  assign fastOscEnable = fastOn;
  assign externalInputEnable = extOn;

  ////////////////////////////////////////////////////////////////////////////
  // source switch sequencing
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    active_next = active_reg;
    fault_next = fault_reg;
    faultEvent = 1'b0;
    swapNow = 1'b0;
    if (wrSwitch) begin
      target_next = source_t'(wrData[SELECT_LSB +: 2]);
      unique case (source_t'(wrData[SELECT_LSB +: 2]))
        SRC_FAST, SRC_EXT, SRC_SLOW: begin
          if (source_ready(source_t'(wrData[SELECT_LSB +: 2]), fastStable,
                           extStable, slowStable)) begin
            state_next = SW_SWAP;
          end else begin
            fault_next = 1'b1;
            faultEvent = 1'b1;
            // a disabled target is dropped; an enabled one is waited for
            if ((source_t'(wrData[SELECT_LSB +: 2]) == SRC_EXT && !extOn) ||
                (source_t'(wrData[SELECT_LSB +: 2]) == SRC_FAST && !fastOn)) begin
              state_next = SW_IDLE;
            end else begin
              state_next = SW_WAIT;
            end
          end
        end
        default: begin
          fault_next = 1'b1;
          faultEvent = 1'b1;
          state_next = SW_IDLE;
        end
      endcase
    end else begin
      unique case (state_reg)
        SW_IDLE: state_next = SW_IDLE;
        SW_WAIT: begin
          if (source_ready(target_reg, fastStable, extStable, slowStable)) begin
            state_next = SW_SWAP;
          end
        end
        SW_SWAP: begin
          if (!source_ready(target_reg, fastStable, extStable, slowStable)) begin
            state_next = SW_WAIT;
          end else if (!sysClk) begin
            // change only while the output is low, so no short pulse leaves
            swapNow = 1'b1;
            active_next = target_reg;
            fault_next = 1'b0;
            state_next = SW_IDLE;
          end
        end
        default: state_next = SW_IDLE;
      endcase
    end
  end

  always_comb begin
    unique case (active_reg)
      SRC_EXT: selLevel = syncB_reg[LANE_EXT_CLK];
      SRC_SLOW: selLevel = syncB_reg[LANE_SLOW_CLK];
      default: selLevel = syncB_reg[LANE_FAST_CLK];
    endcase
  end

  clock_divide_core divider (
    .clk(clk),
    .rstn(rstn),
    .srcLevel(selLevel),
    .restart(swapNow),
    .divFactor(divider_reg),
    .sysClk(sysClk)
  );

  assign activeSource = active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register writes, interrupt status and read port
  always_comb begin
    divider_next = divider_reg;
    extEnable_next = extEnable_reg;
    fastEnable_next = fastEnable_reg;
    irqEnable_next = irqEnable_reg;
    irqEvents = '0;
    irqEvents[IRQ_DONE_BIT] = swapNow;
    irqEvents[IRQ_FAULT_BIT] = faultEvent;
    irqEvents[IRQ_LOCKED_BIT] = wrLocked;
    irqStatus_next = irqStatus_reg;
    if (wrStrobe && addr == DIVIDER_OFFSET) begin
      divider_next = wrData;
    end
    if (wrEnable) begin
      extEnable_next = wrData[EXT_ENABLE_LSB +: 2];
      fastEnable_next = wrData[FAST_ENABLE_BIT];
    end
    if (wrStrobe && addr == IRQ_ENABLE_OFFSET) begin
      irqEnable_next = wrData[IRQ_WIDTH-1:0];
    end
    if (wrStrobe && addr == IRQ_CLEAR_OFFSET) begin
      irqStatus_next = irqStatus_next & ~wrData[IRQ_WIDTH-1:0];
    end
    // a new event wins over a clear in the same cycle
    irqStatus_next = irqStatus_next | irqEvents;
    rdData_next = 8'h00;
    if (rdStrobe) begin
      unique case (addr)
        DIVIDER_OFFSET: rdData_next = divider_reg;
        SWITCH_OFFSET: begin
          // select field reads zero
          rdData_next[FAST_STABLE_BIT] = fastStable;
          rdData_next[SLOW_STABLE_BIT] = slowStable;
          rdData_next[EXT_STABLE_BIT] = extStable;
        end
        ENABLE_OFFSET: begin
          rdData_next[EXT_ENABLE_LSB +: 2] = extEnable_reg;
          rdData_next[FAST_ENABLE_BIT] = fastOn;
          rdData_next[FAULT_BIT] = fault_reg;
        end
        IRQ_STATUS_OFFSET: rdData_next[IRQ_WIDTH-1:0] = irqStatus_reg;
        IRQ_ENABLE_OFFSET: rdData_next[IRQ_WIDTH-1:0] = irqEnable_reg;
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divider_reg <= DIVIDER_RESET;
      extEnable_reg <= ENABLE_RESET[EXT_ENABLE_LSB +: 2];
      fastEnable_reg <= ENABLE_RESET[FAST_ENABLE_BIT];
      fault_reg <= ENABLE_RESET[FAULT_BIT];
      active_reg <= SRC_FAST;
      target_reg <= SRC_FAST;
      state_reg <= SW_IDLE;
      irqStatus_reg <= '0;
      irqEnable_reg <= '0;
      rdData_reg <= 8'h00;
    end else begin
      divider_reg <= divider_next;
      extEnable_reg <= extEnable_next;
      fastEnable_reg <= fastEnable_next;
      fault_reg <= fault_next;
      active_reg <= active_next;
      target_reg <= target_next;
      state_reg <= state_next;
      irqStatus_reg <= irqStatus_next;
      irqEnable_reg <= irqEnable_next;
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
  assign irq = |(irqStatus_reg & irqEnable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_fast_status;
    rdStrobe && addr == SWITCH_OFFSET |=>
      rdData[FAST_STABLE_BIT] == $past(inAppProgramming | (fastOn & syncB_reg[LANE_FAST_RDY]));
  endproperty
  a_fast_status: assert property (p_fast_status) else $error("fast status wrong");

  property p_ext_status;
    rdStrobe && addr == SWITCH_OFFSET |=>
      rdData[EXT_STABLE_BIT] == $past(extOn & syncB_reg[LANE_EXT_RDY]);
  endproperty
  a_ext_status: assert property (p_ext_status) else $error("external status wrong");

  property p_select_hidden;
    rdStrobe && addr == SWITCH_OFFSET |=> rdData[SELECT_LSB +: 2] == 2'h0;
  endproperty
  a_select_hidden: assert property (p_select_hidden) else $error("select field visible");

  property p_ext_enable;
    wrStrobe && accessUnlocked && addr == ENABLE_OFFSET |=>
      externalInputEnable == ($past(wrData[EXT_ENABLE_LSB +: 2]) == EXT_ENABLE_ON);
  endproperty
  a_ext_enable: assert property (p_ext_enable) else $error("external enable wrong");

  property p_fast_off;
    wrEnable && !wrData[FAST_ENABLE_BIT] && !inAppProgramming ##1 !inAppProgramming
      |-> !fastOscEnable;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast oscillator not off");

  property p_iap_force;
    inAppProgramming |-> fastOscEnable && fastStable;
  endproperty
  a_iap_force: assert property (p_iap_force) else $error("programming did not force");

  property p_iap_restore;
    $fell(inAppProgramming) |-> fastOscEnable == fastEnable_reg;
  endproperty
  a_iap_restore: assert property (p_iap_restore) else $error("enable not restored");

  property p_fault_clear;
    swapNow |=> !fault_reg && activeSource == $past(target_reg);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

  property p_fault_disabled;
    wrSwitch && wrData[SELECT_LSB +: 2] == SRC_EXT && !extOn |=> fault_reg ##0 $stable(activeSource);
  endproperty
  a_fault_disabled: assert property (p_fault_disabled) else $error("fault missing");

  property p_locked;
    wrLocked |=> $stable(extEnable_reg) && $stable(fastEnable_reg) && $stable(target_reg);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");

  property p_glitch_free;
    $changed(activeSource) |-> $past(state_reg) == SW_SWAP && !$past(sysClk);
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("unsafe source change");

  c_switch_done: cover property (state_reg == SW_WAIT ##[1:50] swapNow);
  c_fault: cover property (faultEvent);
  c_iap: cover property ($rose(inAppProgramming) ##[1:20] $fell(inAppProgramming));
  c_irq: cover property ($rose(irq));
endmodule

// ### clock_source_pkg.sv
// constants shared by the clock source selector and its divider
package clock_source_pkg;
  localparam logic [7:0] DIVIDER_OFFSET = 8'h95;
  localparam logic [7:0] SWITCH_OFFSET = 8'h96;
  localparam logic [7:0] ENABLE_OFFSET = 8'h97;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hA0;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'hA1;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'hA2;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h30;
  localparam int FAST_STABLE_BIT = 5;
  localparam int SLOW_STABLE_BIT = 4;
  localparam int EXT_STABLE_BIT = 3;
  localparam int SELECT_LSB = 1;
  localparam int EXT_ENABLE_LSB = 6;
  localparam int FAST_ENABLE_BIT = 5;
  localparam int FAULT_BIT = 0;
  localparam logic [1:0] EXT_ENABLE_ON = 2'h3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_LOCKED_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // synchroniser lanes: oscillator levels then stability flags
  localparam int LANE_FAST_CLK = 0;
  localparam int LANE_EXT_CLK = 1;
  localparam int LANE_SLOW_CLK = 2;
  localparam int LANE_FAST_RDY = 3;
  localparam int LANE_EXT_RDY = 4;
  localparam int LANE_SLOW_RDY = 5;
  localparam int LANES = 6;
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_EXT = 2'h1,
    SRC_SLOW = 2'h2,
    SRC_RESERVED = 2'h3
  } source_t;
  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_WAIT = 2'h1,
    SW_SWAP = 2'h3
  } switch_state_t;
endpackage

// ### clock_divide_core.sv
// divides the selected oscillator level by twice the programmed factor; a factor of zero passes it undivided
`timescale 1ns/1ps
module clock_divide_core
  import clock_source_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // source and control
  input wire logic srcLevel,
  input wire logic restart,
  input wire logic [7:0] divFactor,
  // divided clock
  output logic sysClk
);
  logic prevLevel_reg, prevLevel_next;
  logic [7:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic rise;

  always_comb begin
    rise = srcLevel & ~prevLevel_reg;
    prevLevel_next = srcLevel;
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (restart) begin
      cnt_next = 8'h00;
      out_next = 1'b0;
    end else if (divFactor == 8'h00) begin
      cnt_next = 8'h00;
      out_next = srcLevel;
    end else if (rise) begin
      // toggle every divFactor source periods: output period is twice that
      if (cnt_reg >= divFactor - 8'h01) begin
        cnt_next = 8'h00;
        out_next = ~out_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevLevel_reg <= 1'b0;
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      prevLevel_reg <= prevLevel_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign sysClk = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_undivided;
    @(posedge clk) disable iff (!rstn)
    (divFactor == 8'h00 && !restart) |=> (sysClk == $past(srcLevel));
  endproperty
  a_undivided: assert property (p_undivided) else $error("undivided clock mismatch");

  property p_divided_toggle;
    @(posedge clk) disable iff (!rstn)
    (!restart && divFactor != 8'h00 && !rise) |=> $stable(sysClk);
  endproperty
  a_divided_toggle: assert property (p_divided_toggle) else $error("divided clock moved");
endmodule

// ### osc_model.sv
// oscillators and external clock source facing the selector
`timescale 1ns/1ps
module osc_model #(
  parameter real FAST_HALF_NS = 31.25,
  parameter int EXT_HALF_NS = 24,
  parameter int SLOW_HALF_NS = 50000,
  parameter int READY_NS = 400
) (
  // enables from the selector, health of the external source
  input wire logic fastOscEnable,
  input wire logic externalInputEnable,
  input wire logic extGood,
  // oscillator levels and stability
  output logic fastOscClk,
  output logic fastOscReady,
  output logic slowOscClk,
  output logic slowOscReady,
  output logic externalClockPin,
  output logic externalClockReady
);
  ////////////////////////////////////////////////////////////////
  // fast oscillator stands still while disabled
  always begin
    if (fastOscEnable === 1'b1) begin
      #FAST_HALF_NS fastOscClk = ~fastOscClk;
    end else begin
      fastOscClk = 1'b0;
      @(fastOscEnable);
    end
  end
  always begin
    fastOscReady = 1'b0;
    wait (fastOscEnable === 1'b1);
    #READY_NS fastOscReady = (fastOscEnable === 1'b1);
    wait (fastOscEnable !== 1'b1);
  end
  ////////////////////////////////////////////////////////////////
  // slow oscillator always runs; external source free-runs
  initial begin
    slowOscReady = 1'b0;
    #READY_NS slowOscReady = 1'b1;
  end
  initial begin
    slowOscClk = 1'b0;
    forever #SLOW_HALF_NS slowOscClk = ~slowOscClk;
  end
  initial begin
    externalClockPin = 1'b0;
    #3;
    forever #EXT_HALF_NS externalClockPin = ~externalClockPin;
  end
  // unstable on command of the bench
  always begin
    externalClockReady = 1'b0;
    wait (externalInputEnable === 1'b1 && extGood === 1'b1);
    #READY_NS externalClockReady = (externalInputEnable === 1'b1 && extGood === 1'b1);
    wait (!(externalInputEnable === 1'b1 && extGood === 1'b1));
  end
endmodule

// ### tb.sv
// self-checking bench for the clock source selector
`timescale 1ns/1ps
module tb
  import clock_source_pkg::*;
;
  logic clk, rstn, wrStrobe, rdStrobe, accessUnlocked, inAppProgramming, extGood;
  logic [7:0] addr, wrData, rdData;
  logic fastOscClk, fastOscReady, slowOscClk, slowOscReady;
  logic externalClockPin, externalClockReady;
  logic fastOscEnable, externalInputEnable, sysClk, irq;
  logic [1:0] activeSource;
  int errors, n_tests;

  clock_source_ctrl u_clock_source_ctrl (
    .clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .accessUnlocked(accessUnlocked), .inAppProgramming(inAppProgramming),
    .fastOscClk(fastOscClk), .fastOscReady(fastOscReady),
    .slowOscClk(slowOscClk), .slowOscReady(slowOscReady),
    .externalClockPin(externalClockPin), .externalClockReady(externalClockReady),
    .fastOscEnable(fastOscEnable), .externalInputEnable(externalInputEnable),
    .activeSource(activeSource), .sysClk(sysClk), .irq(irq)
  );
  osc_model u_osc_model (
    .fastOscEnable(fastOscEnable), .externalInputEnable(externalInputEnable),
    .extGood(extGood), .fastOscClk(fastOscClk), .fastOscReady(fastOscReady),
    .slowOscClk(slowOscClk), .slowOscReady(slowOscReady),
    .externalClockPin(externalClockPin), .externalClockReady(externalClockReady)
  );
  ////////////////////////////////////////////////////////////////
  // bus and compare helpers
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    accessUnlocked <= u;
    @(posedge clk);
    wrStrobe <= 1'b0;
    accessUnlocked <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  task rdChk(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(name, d & m, e);
  endtask
  task pollBit(input logic [7:0] a, input int b, input logic e);
    logic [7:0] d;
    for (int i = 0; i < 300; i++) begin
      rd(a, d);
      if (d[b] === e) break;
    end
    check("statusBit", d[b], e);
  endtask
  task waitSrc(input logic [1:0] s);
    for (int i = 0; i < 20000 && activeSource !== s; i++) @(negedge clk);
    check("activeSource", activeSource, s);
  endtask
  task riseWait(output int n);
    logic p;
    p = sysClk;
    for (n = 1; n < 5000; n++) begin
      @(negedge clk);
      if (p === 1'b0 && sysClk === 1'b1) break;
      p = sysClk;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task resetValues;
    rdChk("divider", DIVIDER_OFFSET, 8'hFF, DIVIDER_RESET);
    rdChk("enableReg", ENABLE_OFFSET, 8'hE1, 8'h20);
    rdChk("selectReadback", SWITCH_OFFSET, 8'h06, 8'h00);
    check("activeSource", activeSource, SRC_FAST);
  endtask
  task statusAndEnables;
    pollBit(SWITCH_OFFSET, FAST_STABLE_BIT, 1'b1);
    rdChk("extStable", SWITCH_OFFSET, 8'h08, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr(ENABLE_OFFSET, {v[1:0], 6'h20}, 1'b1);
      @(negedge clk);
      check("extEnable", externalInputEnable, v == 3);
    end
    pollBit(SWITCH_OFFSET, EXT_STABLE_BIT, 1'b1);
  endtask
  task lockedAndIrq;
    wr(IRQ_CLEAR_OFFSET, 8'h07, 1'b0);
    wr(IRQ_ENABLE_OFFSET, 8'h04, 1'b0);
    wr(ENABLE_OFFSET, 8'h00, 1'b0);
    @(negedge clk);
    check("extEnable", externalInputEnable, 1'b1);
    check("fastEnable", fastOscEnable, 1'b1);
    check("irq", irq, 1'b1);
    rdChk("irqStatus", IRQ_STATUS_OFFSET, 8'h04, 8'h04);
    wr(IRQ_ENABLE_OFFSET, 8'h00, 1'b0);
    @(negedge clk);
    check("irqMasked", irq, 1'b0);
    wr(IRQ_ENABLE_OFFSET, 8'h04, 1'b0);
    wr(IRQ_CLEAR_OFFSET, 8'h04, 1'b0);
    @(negedge clk);
    check("irqCleared", irq, 1'b0);
  endtask
  task switchFaults;
    wr(SWITCH_OFFSET, 8'h06, 1'b1);
    rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h01);
    rdChk("selectHidden", SWITCH_OFFSET, 8'h06, 8'h00);
    wr(ENABLE_OFFSET, 8'h20, 1'b1);
    wr(SWITCH_OFFSET, 8'h02, 1'b1);
    rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h01);
    extGood <= 1'b0;
    wr(ENABLE_OFFSET, 8'hE0, 1'b1);
    wr(SWITCH_OFFSET, 8'h02, 1'b1);
    repeat (4) rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h01);
    check("activeSource", activeSource, SRC_FAST);
    extGood <= 1'b1;
    waitSrc(SRC_EXT);
    rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h00);
  endtask
  task dividerRates;
    logic [7:0] f [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    int p [4] = '{6, 12, 24, 3060};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(DIVIDER_OFFSET, f[i], 1'b0);
      rdChk("divider", DIVIDER_OFFSET, 8'hFF, f[i]);
      riseWait(n);
      riseWait(n);
      riseWait(n);
      check("sysClkPeriod", n, p[i]);
    end
    wr(DIVIDER_OFFSET, 8'h00, 1'b0);
  endtask
  task programmingForce;
    wr(ENABLE_OFFSET, 8'hC0, 1'b1);
    @(negedge clk);
    check("fastEnable", fastOscEnable, 1'b0);
    pollBit(SWITCH_OFFSET, FAST_STABLE_BIT, 1'b0);
    @(posedge clk);
    inAppProgramming <= 1'b1;
    @(negedge clk);
    check("fastEnable", fastOscEnable, 1'b1);
    rdChk("fastEnableBit", ENABLE_OFFSET, 8'h20, 8'h20);
    pollBit(SWITCH_OFFSET, FAST_STABLE_BIT, 1'b1);
    @(posedge clk);
    inAppProgramming <= 1'b0;
    @(negedge clk);
    check("fastEnable", fastOscEnable, 1'b0);
    rdChk("fastEnableBit", ENABLE_OFFSET, 8'h20, 8'h00);
    pollBit(SWITCH_OFFSET, FAST_STABLE_BIT, 1'b0);
    wr(SWITCH_OFFSET, 8'h00, 1'b1);
    rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h01);
    check("activeSource", activeSource, SRC_EXT);
  endtask
  task slowAndBack;
    pollBit(SWITCH_OFFSET, SLOW_STABLE_BIT, 1'b1);
    wr(SWITCH_OFFSET, 8'h04, 1'b1);
    waitSrc(SRC_SLOW);
    rdChk("fault", ENABLE_OFFSET, 8'h01, 8'h00);
    wr(IRQ_CLEAR_OFFSET, 8'h07, 1'b0);
    wr(IRQ_ENABLE_OFFSET, 8'h01, 1'b0);
    wr(ENABLE_OFFSET, 8'hE0, 1'b1);
    pollBit(SWITCH_OFFSET, FAST_STABLE_BIT, 1'b1);
    wr(SWITCH_OFFSET, 8'h00, 1'b1);
    waitSrc(SRC_FAST);
    @(negedge clk);
    check("irqDone", irq, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  // clock, run and verdict
  task results;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    errors++;
    results();
  end
  initial begin
    rstn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    accessUnlocked = 1'b0;
    inAppProgramming = 1'b0;
    extGood = 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    resetValues();
    statusAndEnables();
    lockedAndIrq();
    switchFaults();
    dividerRates();
    programmingForce();
    slowAndBack();
    results();
  end
endmodule
